/* File: shared/cantrx_pkg.sv */
// Package: constants, types and register map of the transceiver mode and wake block
package cantrx_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int ENABLE_SETTLE_US = 10;
    localparam int ENABLE_SETTLE_CYC = ENABLE_SETTLE_US * CLK_MHZ;
    localparam int WAKE_FILTER_MIN_US = 1;
    localparam int WAKE_FILTER_MIN_CYC = WAKE_FILTER_MIN_US * CLK_MHZ;
    localparam int WAKE_FILTER_MAX_US = 1000;
    localparam int WAKE_FILTER_MAX_CYC = WAKE_FILTER_MAX_US * CLK_MHZ;
    localparam int TX_DOM_TIMEOUT_US = 1000;
    localparam int TX_DOM_TIMEOUT_CYC = TX_DOM_TIMEOUT_US * CLK_MHZ;
    localparam int CNT_W = 20;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SYS_MODE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;

    // Mode field codes
    localparam logic [1:0] TRX_OFF = 2'h0;
    localparam logic [1:0] TRX_WAKE = 2'h1;
    localparam logic [1:0] TRX_RXONLY = 2'h2;
    localparam logic [1:0] TRX_NORMAL = 2'h3;
    localparam logic [1:0] MODE_RESET = TRX_OFF;

    // System operating mode codes
    localparam logic [2:0] SYS_NORMAL = 3'h0;
    localparam logic [2:0] SYS_STOP = 3'h1;
    localparam logic [2:0] SYS_SLEEP = 3'h2;
    localparam logic [2:0] SYS_RESTART = 3'h3;
    localparam logic [2:0] SYS_FAILSAFE = 3'h4;
    localparam logic [2:0] SYS_RESET = SYS_NORMAL;

    // Interrupt status / enable bit positions
    localparam int BIT_WAKE = 0;
    localparam int BIT_FAIL = 1;
    localparam int BIT_RESTART = 2;
    localparam int IRQ_W = 3;

    // Wake detector phases
    typedef enum logic [2:0] {
        WK_IDLE, WK_DOM1, WK_REC, WK_DOM2
    } cantrx_wake_e;

    // AHB-Lite request carrier
    typedef struct packed {
        logic sel;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] haddr;
    } cantrx_ahb_req_s;
endpackage

/* File: rtl/cantrx_wake_det.sv */
// Bus wake pattern detector: two filtered dominant phases around a recessive one
`timescale 1ns/1ps
module cantrx_wake_det
    import cantrx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic arm,
    input wire logic busDominant,
    output logic wakeSeen
);

    cantrx_wake_e state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic wakeSeen_r, wakeSeen_nxt;
    logic inWindow;
    logic tooLong;

    assign wakeSeen = wakeSeen_r;

    // Phase length check against the two filter limits
    assign inWindow = (cnt_r > CNT_W'(WAKE_FILTER_MIN_CYC)) && (cnt_r < CNT_W'(WAKE_FILTER_MAX_CYC));
    assign tooLong = (cnt_r >= CNT_W'(WAKE_FILTER_MAX_CYC));

    // Phase tracking; disarmed means stay idle and ignore bus activity
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r == {CNT_W{1'b1}}) ? cnt_r : cnt_r + CNT_W'(1);
        wakeSeen_nxt = 1'b0;
        if (!arm) begin
            state_nxt = WK_IDLE;
            cnt_nxt = '0;
        end else begin
            unique case (state_r)
                WK_IDLE: begin
                    cnt_nxt = '0;
                    if (busDominant) begin
                        state_nxt = WK_DOM1;
                    end
                end
                WK_DOM1: begin
                    if (!busDominant) begin
                        state_nxt = inWindow ? WK_REC : WK_IDLE;
                        cnt_nxt = '0;
                    end
                end
                WK_REC: begin
                    if (busDominant) begin
                        state_nxt = inWindow ? WK_DOM2 : WK_DOM1;
                        cnt_nxt = '0;
                    end else if (tooLong) begin
                        state_nxt = WK_IDLE;
                    end
                end
                WK_DOM2: begin
                    if (!busDominant) begin
                        wakeSeen_nxt = inWindow;
                        state_nxt = WK_IDLE;
                        cnt_nxt = '0;
                    end
                end
                default: begin
                    state_nxt = WK_IDLE;
                end
            endcase
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= WK_IDLE;
            cnt_r <= '0;
            wakeSeen_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            wakeSeen_r <= wakeSeen_nxt;
        end
    end

    a_wake_needs_arm: assert property (@(posedge clk) disable iff (!rst_n)
        wakeSeen_r |-> $past(arm)) else $error("Wake flagged while disarmed");
endmodule

/* File: rtl/cantrx_tx_gate.sv */
// Transmit gating: enable settling suppression and dominant timeout
`timescale 1ns/1ps
module cantrx_tx_gate
    import cantrx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic txAllowed,
    input wire logic txDataIn,
    output logic drvDominant,
    output logic timeoutHit
);

    logic [CNT_W-1:0] settle_r, settle_nxt;
    logic [CNT_W-1:0] dom_r, dom_nxt;
    logic waitRec_r, waitRec_nxt;
    logic timedOut_r, timedOut_nxt;
    logic drv_r, drv_nxt;
    logic hit_r, hit_nxt;
    logic settled;

    assign drvDominant = drv_r;
    assign timeoutHit = hit_r;
    assign settled = (settle_r == CNT_W'(ENABLE_SETTLE_CYC));

    // Settling count restarts whenever transmit is withdrawn
    always_comb begin
        settle_nxt = settle_r;
        waitRec_nxt = waitRec_r;
        dom_nxt = dom_r;
        timedOut_nxt = timedOut_r;
        hit_nxt = 1'b0;
        if (!txAllowed) begin
            settle_nxt = '0;
            waitRec_nxt = 1'b0;
            dom_nxt = '0;
            timedOut_nxt = 1'b0;
        end else begin
            if (!settled) begin
                settle_nxt = settle_r + CNT_W'(1);
                if (!txDataIn) begin
                    waitRec_nxt = 1'b1;
                end
            end else if (txDataIn) begin
                waitRec_nxt = 1'b0;
            end
            // Dominant timer; release of input re-enables driver
            if (txDataIn) begin
                dom_nxt = '0;
                timedOut_nxt = 1'b0;
            end else if (dom_r != CNT_W'(TX_DOM_TIMEOUT_CYC)) begin
                dom_nxt = dom_r + CNT_W'(1);
            end else if (!timedOut_r) begin
                timedOut_nxt = 1'b1;
                hit_nxt = 1'b1;
            end
        end
        // Drive only when settled, armed by a recessive, and not timed out
        drv_nxt = txAllowed && settled && !waitRec_nxt && !txDataIn && !timedOut_nxt;
    end

    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            settle_r <= '0;
            dom_r <= '0;
            waitRec_r <= 1'b0;
            timedOut_r <= 1'b0;
            drv_r <= 1'b0;
            hit_r <= 1'b0;
        end else begin
            settle_r <= settle_nxt;
            dom_r <= dom_nxt;
            waitRec_r <= waitRec_nxt;
            timedOut_r <= timedOut_nxt;
            drv_r <= drv_nxt;
            hit_r <= hit_nxt;
        end
    end

    a_no_drive_unsettled: assert property (@(posedge clk) disable iff (!rst_n)
        drv_r |-> $past(settled)) else $error("Driver active before settling");
    a_drive_needs_low: assert property (@(posedge clk) disable iff (!rst_n)
        drv_r |-> !$past(txDataIn)) else $error("Driver active with recessive input");
endmodule

/* File: rtl/cantrx_mode_wake.sv */
// Transceiver mode control, wake signalling and AHB-Lite register slave
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps

// Summary of operation
// - Power-up in off; off always selectable
// - Off mode ignores wake, bus input floats
// - Mode chosen by writing mode control bits
// - Normal only in normal/stop, set from normal
// - Normal mode drives bus from transmit input
// - Dominant during settling suppressed until next
// - Normal and receive-only report bus on receive
// - Receive-only: no transmit, normal/stop only
// - Wake mode selectable; forced on fail-safe
// - Wake drives receive low until mode change; a stop/fail-safe write also releases it
// - Wake needs two filtered dominants, one recessive
// - Mode keeps reading wake code after wake
// - Rearm by toggling mode or stop/fail-safe
// - Dominant timeout disables driver, sets fail
// - Wake in sleep moves system to restart
module cantrx_mode_wake
    import cantrx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic txDataIn,
    output logic rxDataOut,
    input wire logic busDominantIn,
    output logic busDriveDominant,
    output logic busBiasEn,
    output logic [2:0] sysModeOut,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cantrx_ahb_req_s req_r, req_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic [2:0] sys_r, sys_nxt;
    logic armed_r, armed_nxt;
    logic woken_r, woken_nxt;
    logic [IRQ_W-1:0] stat_r, stat_nxt;
    logic [IRQ_W-1:0] en_r, en_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic rx_r, rx_nxt;
    logic drv_r, drv_nxt;
    logic bias_r, bias_nxt;
    logic irq_r, irq_nxt;
    logic wakeSeen;
    logic gateDrive;
    logic timeoutHit;
    logic wrMode;
    logic wrSys;
    logic wrClr;
    logic wrEn;
    logic [IRQ_W-1:0] evt;
    logic [1:0] reqMode;
    logic [2:0] reqSys;
    logic modeOk;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign rxDataOut = rx_r;
    assign busDriveDominant = drv_r;
    assign busBiasEn = bias_r;
    assign sysModeOut = sys_r;
    assign irq = irq_r;

    // Mode legality per system mode; off is always allowed
    function automatic logic mode_allowed(input logic [1:0] m, input logic [2:0] s);
        logic ok;
        ok = 1'b0;
        unique case (m)
            TRX_OFF: ok = 1'b1;
            TRX_NORMAL: ok = (s == SYS_NORMAL);
            TRX_RXONLY: ok = (s == SYS_NORMAL) || (s == SYS_STOP);
            TRX_WAKE: ok = (s != SYS_FAILSAFE);
        endcase
        return ok;
    endfunction

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    // Transmit path is only live in normal mode inside normal/stop
    logic txAllowed;
    assign txAllowed = (mode_r == TRX_NORMAL)
        && ((sys_r == SYS_NORMAL) || (sys_r == SYS_STOP));

    cantrx_tx_gate u_tx_gate (
        .clk(clk),
        .rst_n(rst_n),
        .txAllowed(txAllowed),
        .txDataIn(txDataIn),
        .drvDominant(gateDrive),
        .timeoutHit(timeoutHit)
    );

    // Off mode disarms the detector so bus activity is ignored
    cantrx_wake_det u_wake_det (
        .clk(clk),
        .rst_n(rst_n),
        .arm(armed_r && (mode_r == TRX_WAKE)),
        .busDominant(busDominantIn),
        .wakeSeen(wakeSeen)
    );

    // ------------------------------------------------------------
    // Bus slave: address phase captured, data phase acted upon
    // ------------------------------------------------------------
    always_comb begin
        req_nxt = req_r;
        if (hready) begin
            req_nxt.sel = hsel && htrans[1];
            req_nxt.htrans = htrans;
            req_nxt.hwrite = hwrite;
            req_nxt.hsize = hsize;
            req_nxt.haddr = haddr;
        end
    end

    assign wrMode = req_r.sel && req_r.hwrite && (req_r.haddr[7:0] == ADDR_MODE_CTRL);
    assign wrSys = req_r.sel && req_r.hwrite && (req_r.haddr[7:0] == ADDR_SYS_MODE);
    assign wrClr = req_r.sel && req_r.hwrite && (req_r.haddr[7:0] == ADDR_IRQ_CLR);
    assign wrEn = req_r.sel && req_r.hwrite && (req_r.haddr[7:0] == ADDR_IRQ_EN);
    assign reqMode = hwdata[1:0];
    assign reqSys = hwdata[2:0];
    assign modeOk = mode_allowed(reqMode, sys_r);

    // ------------------------------------------------------------
    // Mode, system mode and wake state
    // ------------------------------------------------------------
    // Illegal mode requests are dropped; a system mode write does not recheck
    // the mode already in the field, which can then be one the system cannot serve.
    always_comb begin
        mode_nxt = mode_r;
        sys_nxt = sys_r;
        armed_nxt = armed_r;
        woken_nxt = woken_r;
        evt = '0;
        if (wrSys && (reqSys <= SYS_FAILSAFE)) begin
            sys_nxt = reqSys;
            if (reqSys == SYS_FAILSAFE) begin
                mode_nxt = TRX_WAKE;
            end
            if ((reqSys == SYS_STOP) || (reqSys == SYS_FAILSAFE)) begin
                armed_nxt = 1'b1;
                woken_nxt = 1'b0;
            end
        end
        if (wrMode && modeOk) begin
            if (hwdata[1:0] != mode_r) begin
                armed_nxt = 1'b1;
                woken_nxt = 1'b0;
            end
            mode_nxt = reqMode;
        end
        // Wake after the write so a same-cycle wake is kept
        if (wakeSeen && armed_r && (mode_r == TRX_WAKE)) begin
            woken_nxt = 1'b1;
            armed_nxt = 1'b0;
            mode_nxt = TRX_WAKE;
            evt[BIT_WAKE] = 1'b1;
            if ((sys_r == SYS_SLEEP) || (sys_r == SYS_FAILSAFE)) begin
                sys_nxt = SYS_RESTART;
                evt[BIT_RESTART] = 1'b1;
            end
        end
        evt[BIT_FAIL] = timeoutHit;
    end

    // ------------------------------------------------------------
    // Pins: receive, driver and bias
    // ------------------------------------------------------------
    always_comb begin
        rx_nxt = 1'b1;
        drv_nxt = 1'b0;
        bias_nxt = (mode_nxt == TRX_NORMAL) || (mode_nxt == TRX_RXONLY);
        unique case (mode_r)
            TRX_NORMAL: begin
                rx_nxt = !busDominantIn;
                drv_nxt = gateDrive;
            end
            TRX_RXONLY: begin
                rx_nxt = !busDominantIn;
            end
            TRX_WAKE: begin
                rx_nxt = !woken_r;
            end
            TRX_OFF: begin
                rx_nxt = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Interrupt status, enable and read data
    // ------------------------------------------------------------
    // Set wins over clear so a same-cycle event is never lost
    always_comb begin
        stat_nxt = stat_r;
        en_nxt = en_r;
        if (wrClr) begin
            stat_nxt = stat_r & ~hwdata[IRQ_W-1:0];
        end
        stat_nxt = stat_nxt | evt;
        if (wrEn) begin
            en_nxt = hwdata[IRQ_W-1:0];
        end
        irq_nxt = |(stat_nxt & en_nxt);
        rdata_nxt = 32'h0000_0000;
        if (req_nxt.sel && !req_nxt.hwrite && hready) begin
            unique case (req_nxt.haddr[7:0])
                ADDR_MODE_CTRL: rdata_nxt = {30'h0, mode_nxt};
                ADDR_SYS_MODE: rdata_nxt = {29'h0, sys_nxt};
                ADDR_STATUS: rdata_nxt = {29'h0, woken_nxt, armed_nxt, rx_nxt};
                ADDR_IRQ_STAT: rdata_nxt = {29'h0, stat_nxt};
                ADDR_IRQ_EN: rdata_nxt = {29'h0, en_nxt};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_r <= '0;
            mode_r <= MODE_RESET;
            sys_r <= SYS_RESET;
            armed_r <= 1'b1;
            woken_r <= 1'b0;
            stat_r <= '0;
            en_r <= '0;
            rdata_r <= 32'h0000_0000;
            rx_r <= 1'b1;
            drv_r <= 1'b0;
            bias_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            req_r <= req_nxt;
            mode_r <= mode_nxt;
            sys_r <= sys_nxt;
            armed_r <= armed_nxt;
            woken_r <= woken_nxt;
            stat_r <= stat_nxt;
            en_r <= en_nxt;
            rdata_r <= rdata_nxt;
            rx_r <= rx_nxt;
            drv_r <= drv_nxt;
            bias_r <= bias_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_off_after_reset: assert property (@(posedge clk)
        $rose(rst_n) |-> mode_r == TRX_OFF) else $error("Not off after reset");
    a_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        $past(mode_r) == TRX_OFF |-> rx_r && !drv_r) else $error("Off mode active");
    a_normal_sys: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(mode_r) && mode_r == TRX_NORMAL |-> $past(sys_r) == SYS_NORMAL)
        else $error("Normal entered outside normal system mode");
    a_rxonly_nodrive: assert property (@(posedge clk) disable iff (!rst_n)
        mode_r == TRX_RXONLY ##1 mode_r == TRX_RXONLY |-> !drv_r)
        else $error("Driver on in receive-only");
    a_rx_follows: assert property (@(posedge clk) disable iff (!rst_n)
        $past(mode_r) == TRX_RXONLY |-> rx_r == !$past(busDominantIn))
        else $error("Receive output wrong");
    a_failsafe_wake: assert property (@(posedge clk) disable iff (!rst_n)
        wrSys && reqSys == SYS_FAILSAFE |=> mode_r == TRX_WAKE)
        else $error("Fail-safe did not force wake mode");
    a_wake_holds_rx: assert property (@(posedge clk) disable iff (!rst_n)
        woken_r && mode_r == TRX_WAKE ##1 mode_r == TRX_WAKE |-> !rx_r)
        else $error("Receive released while woken");
    a_wake_mode_kept: assert property (@(posedge clk) disable iff (!rst_n)
        woken_r && !$past(woken_r) |-> mode_r == TRX_WAKE)
        else $error("Mode left wake code on wake");
    a_sleep_restart: assert property (@(posedge clk) disable iff (!rst_n)
        wakeSeen && armed_r && mode_r == TRX_WAKE && sys_r == SYS_SLEEP && !wrSys
        |=> sys_r == SYS_RESTART) else $error("Sleep wake missed restart");
    a_fail_flag: assert property (@(posedge clk) disable iff (!rst_n)
        timeoutHit |=> stat_r[BIT_FAIL]) else $error("Fail flag not set");
endmodule

/* File: tb/cantrx_ctrl_model.sv */
// Far-side model: protocol controller transmit line and remote bus node
`timescale 1ns/1ps
module cantrx_ctrl_model
    import cantrx_pkg::*;
(
    input wire logic clk,
    input wire logic busDriveDominant,
    output logic txDataIn,
    output logic busDominantIn
);
    // ------------------------------------------------
    // Bus and controller state
    // ------------------------------------------------
    logic remoteDom;

    // Idle recessive on both lines after power-up
    initial begin
        txDataIn = 1'h1;
        remoteDom = 1'h0;
    end

    // Dominant from any node wins on the wire
    assign busDominantIn = remoteDom | busDriveDominant;

    // Controller transmit level, changed just after an edge
    task automatic setTx(input logic v);
        @(posedge clk);
        txDataIn <= v;
    endtask

    // Remote node holds a level for n cycles
    task automatic remote(input logic v, input int n);
        @(posedge clk);
        remoteDom <= v;
        repeat (n - 1) @(posedge clk);
    endtask

    // Two filtered dominant phases around one recessive phase
    task automatic wakePattern(input int n);
        remote(1'h1, n);
        remote(1'h0, n);
        remote(1'h1, n);
        remote(1'h0, n);
    endtask
endmodule

/* File: tb/tb_top.sv */
// Testbench: register access, transceiver modes, transmit gating and wake
`timescale 1ns/1ps
module tb_top
    import cantrx_pkg::*;
;
    // ------------------------------------------------
    // Signals and counters
    // ------------------------------------------------
    logic clk;
    logic rst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout, hresp, rxDataOut, busDriveDominant, busBiasEn, irq;
    logic txDataIn, busDominantIn;
    logic [31:0] hrdata;
    logic [31:0] rv;
    logic [2:0] sysModeOut;
    int miscompares = 0;
    int numChecks = 0;
    int cycles = 0;

    cantrx_mode_wake cantrx_mode_wake_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .txDataIn(txDataIn), .rxDataOut(rxDataOut), .busDominantIn(busDominantIn),
        .busDriveDominant(busDriveDominant), .busBiasEn(busBiasEn),
        .sysModeOut(sysModeOut), .irq(irq));

    cantrx_ctrl_model cantrx_ctrl_model_inst (.clk(clk), .busDriveDominant(busDriveDominant),
        .txDataIn(txDataIn), .busDominantIn(busDominantIn));

    // Free-running 125 MHz clock
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // Hang guard; the whole run needs well under this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            conclude();
        end
    end

    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic conclude();
        $display("checks %0d miscompares %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        numChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %0t %s got %h want %h", $time, m, seen, exp);
        end
    endtask

    // Single AHB word transfer; hrdata taken at the closing edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'h1);
        rv = hrdata;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'h0, a, 32'h0);
        chk(rv, exp, "register read");
    endtask

    // Let registered outputs land before looking
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic tReset();
        rdChk(ADDR_MODE_CTRL, {30'h0, TRX_OFF});
        rdChk(ADDR_SYS_MODE, {29'h0, SYS_NORMAL});
        rdChk(8'h18, 32'h0);
        chk({31'h0, busBiasEn}, 32'h0, "bias at reset");
        chk({31'h0, rxDataOut}, 32'h1, "rx at reset");
        chk({31'h0, hresp}, 32'h0, "okay response");
    endtask

    // Off mode must not react to a valid wake pattern
    task automatic tOffIgnores();
        xfer(1'h1, ADDR_IRQ_EN, 32'h1);
        cantrx_ctrl_model_inst.wakePattern(200);
        settle(5);
        chk({31'h0, rxDataOut}, 32'h1, "rx in off");
        rdChk(ADDR_IRQ_STAT, 32'h0);
    endtask

    task automatic tRxOnly();
        xfer(1'h1, ADDR_MODE_CTRL, {30'h0, TRX_RXONLY});
        rdChk(ADDR_MODE_CTRL, {30'h0, TRX_RXONLY});
        cantrx_ctrl_model_inst.setTx(1'h0);
        cantrx_ctrl_model_inst.remote(1'h1, 4);
        settle(1);
        chk({31'h0, rxDataOut}, 32'h0, "rx follows bus");
        chk({31'h0, busDriveDominant}, 32'h0, "no drive rx only");
        chk({31'h0, busBiasEn}, 32'h1, "receiver biased");
        cantrx_ctrl_model_inst.remote(1'h0, 4);
        cantrx_ctrl_model_inst.setTx(1'h1);
        settle(3);
        chk({31'h0, rxDataOut}, 32'h1, "rx recessive");
    endtask

    // Early dominant during settling is swallowed, next one goes out
    task automatic tNormal();
        xfer(1'h1, ADDR_MODE_CTRL, {30'h0, TRX_NORMAL});
        rdChk(ADDR_MODE_CTRL, {30'h0, TRX_NORMAL});
        cantrx_ctrl_model_inst.setTx(1'h0);
        settle(ENABLE_SETTLE_CYC + 50);
        chk({31'h0, busDriveDominant}, 32'h0, "suppressed");
        cantrx_ctrl_model_inst.setTx(1'h1);
        cantrx_ctrl_model_inst.setTx(1'h0);
        settle(3);
        chk({31'h0, busDriveDominant}, 32'h1, "drive dominant");
        chk({31'h0, rxDataOut}, 32'h0, "rx own dominant");
        cantrx_ctrl_model_inst.setTx(1'h1);
        settle(3);
        chk({31'h0, busDriveDominant}, 32'h0, "drive recessive");
    endtask

    task automatic tWakeSleep();
        xfer(1'h1, ADDR_MODE_CTRL, {30'h0, TRX_WAKE});
        xfer(1'h1, ADDR_SYS_MODE, {29'h0, SYS_SLEEP});
        xfer(1'h1, ADDR_MODE_CTRL, {30'h0, TRX_NORMAL});
        rdChk(ADDR_MODE_CTRL, {30'h0, TRX_WAKE});
        xfer(1'h1, ADDR_MODE_CTRL, {30'h0, TRX_RXONLY});
        rdChk(ADDR_MODE_CTRL, {30'h0, TRX_WAKE});
        cantrx_ctrl_model_inst.wakePattern(200);
        settle(5);
        chk({31'h0, rxDataOut}, 32'h0, "rx low on wake");
        rdChk(ADDR_SYS_MODE, {29'h0, SYS_RESTART});
        chk({29'h0, sysModeOut}, {29'h0, SYS_RESTART}, "system mode pin");
        rdChk(ADDR_MODE_CTRL, {30'h0, TRX_WAKE});
        rdChk(ADDR_IRQ_STAT, 32'h5);
        chk({31'h0, irq}, 32'h1, "irq raised");
        xfer(1'h1, ADDR_IRQ_EN, 32'h0);
        settle(2);
        chk({31'h0, irq}, 32'h0, "irq masked");
        xfer(1'h1, ADDR_IRQ_EN, 32'h1);
        xfer(1'h1, ADDR_IRQ_CLR, 32'h7);
        settle(2);
        chk({31'h0, irq}, 32'h0, "irq cleared");
    endtask

    // Toggle away and back rearms; held low until the mode changes
    task automatic tRearm();
        xfer(1'h1, ADDR_MODE_CTRL, {30'h0, TRX_OFF});
        settle(3);
        chk({31'h0, rxDataOut}, 32'h1, "rx released");
        chk({31'h0, busBiasEn}, 32'h0, "off input floats");
        xfer(1'h1, ADDR_MODE_CTRL, {30'h0, TRX_WAKE});
        // Phases below the lower filter limit must not wake
        cantrx_ctrl_model_inst.wakePattern(50);
        settle(5);
        chk({31'h0, rxDataOut}, 32'h1, "short pattern ignored");
        cantrx_ctrl_model_inst.wakePattern(200);
        settle(5);
        chk({31'h0, rxDataOut}, 32'h0, "rearmed wake");
        xfer(1'h1, ADDR_MODE_CTRL, {30'h0, TRX_OFF});
        xfer(1'h1, ADDR_SYS_MODE, {29'h0, SYS_FAILSAFE});
        rdChk(ADDR_MODE_CTRL, {30'h0, TRX_WAKE});
        xfer(1'h1, ADDR_SYS_MODE, {29'h0, SYS_NORMAL});
        xfer(1'h1, ADDR_MODE_CTRL, {30'h0, TRX_NORMAL});
        rdChk(ADDR_MODE_CTRL, {30'h0, TRX_NORMAL});
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        rst_n <= 1'h0;
        hsel <= 1'h0;
        haddr <= 32'h0;
        htrans <= 2'h0;
        hwrite <= 1'h0;
        hsize <= 3'h2;
        hwdata <= 32'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        tReset();
        tOffIgnores();
        tRxOnly();
        tNormal();
        tWakeSleep();
        tRearm();
        conclude();
    end
endmodule
